// *** rtl/parallel_ports.sv ***
// Purpose: bidirectional general purpose parallel ports
// Assumes: cpu access strobes are one-cycle pulses on ref_clk
// Notes: ports indexed 0..8 as p0l,p0h,p1l,p1h,p2,p3,p4,p6,p7
`timescale 1ns/1ps
`include "gpio_port_defs.svh"
module parallel_ports
  import gpio_port_pkg::*;
(
  // clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          rstn,
  // cpu access
  input  wire op_type                        op,
  input  wire logic [3:0]                    port_sel,
  input  wire logic [2:0]                    field_sel,
  input  wire logic [`LANE_W-1:0]            wr_data,
  input  wire logic [`LANE_W-1:0]            bit_mask,
  input  wire rmw_fn_type                    rmw_fn,
  input  wire logic                          powerdown,
  output logic      [`LANE_W-1:0]            rd_data,
  // pads
  input  wire logic [`NUM_PORTS*`LANE_W-1:0] pad_in,
  output logic      [`NUM_PORTS*`LANE_W-1:0] pad_out,
  output logic      [`NUM_PORTS*`LANE_W-1:0] pad_oe_n,
  output logic      [`NUM_PORTS*`LANE_W-1:0] pull_up,
  output logic      [`NUM_PORTS*`LANE_W-1:0] pull_down
);
  // port widths, lanes above a port's width stay zero, except pad_oe_n which stays one
  localparam int unsigned WIDTHS [`NUM_PORTS] = '{`W_P0L, `W_P0H, `W_P1L, `W_P1H,
    `W_P2, `W_P3, `W_P4, `W_P6, `W_P7};

  typedef struct packed {
    logic [`NUM_PORTS-1:0][`LANE_W-1:0] dir;
    logic [`NUM_PORTS-1:0][`LANE_W-1:0] latch;
    logic [`NUM_PORTS-1:0][`LANE_W-1:0] od;
    logic [`NUM_PORTS-1:0][`LANE_W-1:0] pen;
    logic [`NUM_PORTS-1:0][`LANE_W-1:0] psel;
    logic [`NUM_PORTS-1:0][`LANE_W-1:0] hold;
    logic [`NUM_PORTS-1:0][`LANE_W-1:0] pin;
    logic [`NUM_PORTS-1:0][`LANE_W-1:0] pout;
    logic [`NUM_PORTS-1:0][`LANE_W-1:0] poe_n;
    logic [`NUM_PORTS-1:0][`LANE_W-1:0] pup;
    logic [`NUM_PORTS-1:0][`LANE_W-1:0] pdn;
    logic                 pd;
    logic [`LANE_W-1:0]   rd;
  } state_type;

  state_type st;
  state_type next_st;

  logic [`NUM_PORTS-1:0][`LANE_W-1:0] wmask;
  logic [`NUM_PORTS-1:0][`LANE_W-1:0] d_out;
  logic [`NUM_PORTS-1:0][`LANE_W-1:0] d_oe_n;
  logic [`NUM_PORTS-1:0][`LANE_W-1:0] d_pu;
  logic [`NUM_PORTS-1:0][`LANE_W-1:0] d_pd;
  logic [`NUM_PORTS-1:0][`LANE_W-1:0] rdv;
  logic [`NUM_PORTS-1:0][`LANE_W-1:0] rmwv;

  genvar p;
  generate
    for (p = 0; p < `NUM_PORTS; p = p + 1)
    begin : g_port
      // lanes that exist on this port
      assign wmask[p] = 16'hffff >> (`LANE_W - WIDTHS[p]);
      pin_driver u_drv (
        .dir       (st.dir[p]),
        .latch     (st.latch[p]),
        .od        (st.od[p]),
        .pen       (st.pen[p]),
        .psel      (st.psel[p]),
        .hold      (st.hold[p]),
        .powerdown (st.pd),
        .pad_out   (d_out[p]),
        .pad_oe_n  (d_oe_n[p]),
        .pull_up   (d_pu[p]),
        .pull_down (d_pd[p])
      );
      rmw_unit u_rmw (
        .dir        (st.dir[p]),
        .latch      (st.latch[p]),
        .pin_sample (st.pin[p]),
        .fn         (rmw_fn),
        .operand    (wr_data),
        .read_val   (rdv[p]),
        .rmw_val    (rmwv[p])
      );
    end
  endgenerate

  // next state: sampling, cpu writes, pad outputs
  always_comb
  begin
    logic [`LANE_W-1:0] m;
    logic [`LANE_W-1:0] v;
    logic [`LANE_W-1:0] cur;
    next_st = st;
    m = 16'h0000;
    v = 16'h0000;
    cur = 16'h0000;
    next_st.pd = powerdown;
    for (int k = 0; k < `NUM_PORTS; k++)
    begin
      next_st.pin[k]   = pad_in[k*`LANE_W +: `LANE_W] & wmask[k];
      next_st.pout[k]  = d_out[k] & wmask[k];
      next_st.poe_n[k] = d_oe_n[k] | ~wmask[k];
      next_st.pup[k]   = d_pu[k] & wmask[k];
      next_st.pdn[k]   = d_pd[k] & wmask[k];
    end
    // read path shows latch or pin per line for field 0, the selected control field for fields 1 to 5, else zero
    next_st.rd = 16'h0000;
    if (port_sel < 4'(`NUM_PORTS))
    begin
      m = bit_mask & wmask[port_sel];
      case (field_sel)
        3'h0: cur = rdv[port_sel];
        3'h1: cur = st.dir[port_sel];
        3'h2: cur = st.od[port_sel];
        3'h3: cur = st.pen[port_sel];
        3'h4: cur = st.psel[port_sel];
        3'h5: cur = st.hold[port_sel];
        default: cur = 16'h0000;
      endcase
      next_st.rd = cur & wmask[port_sel];
      if (op == op_rmw)
      begin
        v = (field_sel == 3'h0) ? rmwv[port_sel] : ((cur & ~wr_data) | wr_data);
      end
      else
      begin
        v = wr_data;
      end
      if (op != op_idle)
      begin
        case (field_sel)
          3'h0: next_st.latch[port_sel] = (st.latch[port_sel] & ~m) | (v & m);
          3'h1: next_st.dir[port_sel]   = (st.dir[port_sel] & ~m) | (v & m);
          3'h2: next_st.od[port_sel]    = (st.od[port_sel] & ~m) | (v & m);
          3'h3: next_st.pen[port_sel]   = (st.pen[port_sel] & ~m) | (v & m);
          3'h4: next_st.psel[port_sel]  = (st.psel[port_sel] & ~m) | (v & m);
          3'h5: next_st.hold[port_sel]  = (st.hold[port_sel] & ~m) | (v & m);
          default: next_st.latch[port_sel] = st.latch[port_sel];
        endcase
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      for (int k = 0; k < `NUM_PORTS; k++)
      begin
        st.dir[k]   <= `DIR_RESET;
        st.latch[k] <= `LATCH_RESET;
        st.od[k]    <= `OD_RESET;
        st.pen[k]   <= `PEN_RESET;
        st.psel[k]  <= `PSEL_RESET;
        st.hold[k]  <= `HOLD_RESET;
        st.pin[k]   <= 16'h0000;
        st.pout[k]  <= 16'h0000;
        st.poe_n[k] <= 16'hffff;
        st.pup[k]   <= 16'h0000;
        st.pdn[k]   <= 16'h0000;
      end
      st.pd <= 1'b0;
      st.rd <= 16'h0000;
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs straight from flip-flops
  assign rd_data   = st.rd;
  assign pad_out   = st.pout;
  assign pad_oe_n  = st.poe_n;
  assign pull_up   = st.pup;
  assign pull_down = st.pdn;
endmodule

// *** rtl/gpio_port_defs.svh ***
// Purpose: constants for the bidirectional parallel port block
// Assumes: one 16-bit lane slice per port, unused lanes tie to zero, pad_oe_n lanes to one
// Notes: widths of every port and reset values of control bits
`ifndef GPIO_PORT_DEFS_SVH
`define GPIO_PORT_DEFS_SVH
`define LANE_W        16
`define NUM_PORTS     9
`define DIR_RESET     16'h0000
`define LATCH_RESET   16'h0000
`define OD_RESET      16'h0000
`define PEN_RESET     16'h0000
`define PSEL_RESET    16'h0000
`define HOLD_RESET    16'h0000
`define W_P0L         8
`define W_P0H         8
`define W_P1L         8
`define W_P1H         8
`define W_P2          14
`define W_P3          16
`define W_P4          6
`define W_P6          3
`define W_P7          10
`endif

// *** rtl/gpio_port_pkg.sv ***
// Purpose: types for the parallel port block
// Assumes: gpio_port_defs.svh constants
// Notes: operations a cpu access may request
package gpio_port_pkg;
  typedef enum logic [1:0] {op_idle, op_write, op_rmw} op_type;
  typedef enum logic [1:0] {f_and, f_or, f_xor, f_pass} rmw_fn_type;
endpackage

// *** rtl/pin_driver.sv ***
// Purpose: per-line pad control for one port
// Assumes: pad levels are resolved outside from the enables
// Notes: oe is low while the line drives
`timescale 1ns/1ps
`include "gpio_port_defs.svh"
module pin_driver
  import gpio_port_pkg::*;
(
  // settings
  input  wire logic [`LANE_W-1:0] dir,
  input  wire logic [`LANE_W-1:0] latch,
  input  wire logic [`LANE_W-1:0] od,
  input  wire logic [`LANE_W-1:0] pen,
  input  wire logic [`LANE_W-1:0] psel,
  input  wire logic [`LANE_W-1:0] hold,
  input  wire logic               powerdown,
  // pad controls
  output logic      [`LANE_W-1:0] pad_out,
  output logic      [`LANE_W-1:0] pad_oe_n,
  output logic      [`LANE_W-1:0] pull_up,
  output logic      [`LANE_W-1:0] pull_down
);
  genvar i;
  generate
    for (i = 0; i < `LANE_W; i = i + 1)
    begin : g_line
      logic drv_ok;
      logic drv;
      // driver allowed unless in power-down with hold clear
      assign drv_ok = ~powerdown | hold[i];
      // open-drain only drives a low; push/pull drives both levels
      assign drv = dir[i] & drv_ok & (~od[i] | ~latch[i]);
      assign pad_out[i]  = od[i] ? 1'b0 : latch[i];
      assign pad_oe_n[i] = ~drv;
      assign pull_up[i]   = pen[i] & psel[i];
      assign pull_down[i] = pen[i] & ~psel[i];
    end
  endgenerate
endmodule

// *** rtl/rmw_unit.sv ***
// Purpose: read source and read-modify-write result for one port
// Assumes: sampled pins and latch are registered values
// Notes: combinational
`timescale 1ns/1ps
`include "gpio_port_defs.svh"
module rmw_unit
  import gpio_port_pkg::*;
(
  // state
  input  wire logic [`LANE_W-1:0] dir,
  input  wire logic [`LANE_W-1:0] latch,
  input  wire logic [`LANE_W-1:0] pin_sample,
  // operation
  input  wire rmw_fn_type         fn,
  input  wire logic [`LANE_W-1:0] operand,
  // result
  output logic      [`LANE_W-1:0] read_val,
  output logic      [`LANE_W-1:0] rmw_val
);
  // per line: latch for outputs, pin for inputs
  assign read_val = (dir & latch) | (~dir & pin_sample);
  // modify step
  always_comb
  begin
    case (fn)
      f_and:   rmw_val = read_val & operand;
      f_or:    rmw_val = read_val | operand;
      f_xor:   rmw_val = read_val ^ operand;
      default: rmw_val = operand;
    endcase
  end
endmodule

// *** tb/parallel_ports_properties.sv ***
// Purpose: port-level checks for the parallel port block
// Assumes: port_sel 4 is the 14-bit port, lane bits 64..79
// Notes: bound into every parallel_ports instance
`timescale 1ns/1ps
module parallel_ports_properties
  import gpio_port_pkg::*;
(
  // clock and reset
  input wire logic         ref_clk,
  input wire logic         rstn,
  // cpu access
  input wire op_type       op,
  input wire logic [3:0]   port_sel,
  input wire logic [2:0]   field_sel,
  input wire logic [15:0]  wr_data,
  input wire logic [15:0]  bit_mask,
  input wire logic [15:0]  rd_data,
  // pads
  input wire logic [143:0] pad_oe_n,
  input wire logic [143:0] pull_up,
  input wire logic [143:0] pull_down
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // single-bit writes to lane 0 of the 14-bit port
  sequence s_wr(f, v);
    op == op_write && port_sel == 4'h4 && field_sel == f && bit_mask[0] && wr_data[0] == v
      ##1 op == op_idle;
  endsequence
  sequence s_dir_rd;
    op == op_write && port_sel == 4'h4 && field_sel == 3'h1 && bit_mask[0]
      ##1 op == op_idle && port_sel == 4'h4 && field_sel == 3'h1;
  endsequence
  reset_idle_a: assert property (@(posedge ref_clk) disable iff (1'b0)
    !rstn |=> &pad_oe_n && pull_up == '0 && pull_down == '0 && rd_data == 16'h0000)
    else $error("outputs not idle after reset");
  dir_off_a: assert property (s_wr(3'h1, 1'b0) |=> pad_oe_n[64])
    else $error("input line still driven");
  pull_off_a: assert property (s_wr(3'h3, 1'b0) |=> !pull_up[64] && !pull_down[64])
    else $error("pull still on after disable");
  dir_readback_a: assert property (s_dir_rd |=> rd_data[0] == $past(wr_data[0], 2))
    else $error("direction bit read back wrong");
  unused_lane_a: assert property (
    &{pad_oe_n[78 +: 2], pad_oe_n[102 +: 10], pad_oe_n[115 +: 13], pad_oe_n[138 +: 6]})
    else $error("lane beyond port width driven");
  pull_excl_a: assert property ((pull_up & pull_down) == '0)
    else $error("pull-up and pull-down both on");
  bad_port_a: assert property (port_sel >= 4'h9 |=> rd_data == 16'h0000)
    else $error("unmapped port read not zero");
  bad_field_a: assert property (field_sel[2:1] == 2'b11 |=> rd_data == 16'h0000)
    else $error("unused field read not zero");
endmodule
bind parallel_ports parallel_ports_properties u_props (.ref_clk(ref_clk), .rstn(rstn), .op(op),
  .port_sel(port_sel), .field_sel(field_sel), .wr_data(wr_data), .bit_mask(bit_mask),
  .rd_data(rd_data), .pad_oe_n(pad_oe_n), .pull_up(pull_up), .pull_down(pull_down));

// *** tb/pad_board.sv ***
// Purpose: board wiring seen by the port pins
// Assumes: board drivers drive both levels and combine with the chip drivers as a wired-AND
// Notes: a floating pin toggles every cycle
`timescale 1ns/1ps
module pad_board
(
  // clock
  input  wire logic         ref_clk,
  // chip side
  input  wire logic [143:0] pad_out,
  input  wire logic [143:0] pad_oe_n,
  input  wire logic [143:0] pull_up,
  input  wire logic [143:0] pull_down,
  // board side
  input  wire logic [143:0] ext_val,
  input  wire logic [143:0] ext_en,
  output logic      [143:0] pad_in
);
  logic [143:0] drv;
  logic [143:0] last = '0;
  // wired-AND of all drivers, else pull, else a floating pattern
  assign drv = ~pad_oe_n | ext_en;
  assign pad_in = (drv & (pad_oe_n | pad_out) & (~ext_en | ext_val))
    | (~drv & (pull_up | (~pull_down & ~last)));
  // remember the level so a floating pin never holds it
  always @(posedge ref_clk) last <= pad_in;
endmodule

// *** tb/testbench.sv ***
// Purpose: directed test of the parallel port block
// Assumes: all traffic on the 14-bit port, lane bits 64..79, apart from one read of unmapped port 9
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
module testbench;
  import gpio_port_pkg::*;
  logic         ref_clk = 0, rstn = 0, powerdown = 0;
  op_type       op = op_idle;
  rmw_fn_type   rmw_fn = f_pass;
  logic [3:0]   port_sel = 4'h4;
  logic [2:0]   field_sel = 3'h0;
  logic [15:0]  wr_data = '0, bit_mask = '0, rd_data;
  logic [143:0] pad_in, pad_out, pad_oe_n, pull_up, pull_down, ext_val = '0, ext_en = '0;
  int           num_errors = 0, checks_done = 0;
  parallel_ports u_dut (.ref_clk(ref_clk), .rstn(rstn), .op(op), .port_sel(port_sel),
    .field_sel(field_sel), .wr_data(wr_data), .bit_mask(bit_mask), .rmw_fn(rmw_fn),
    .powerdown(powerdown), .rd_data(rd_data), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .pull_up(pull_up), .pull_down(pull_down));
  pad_board u_board (.ref_clk(ref_clk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pull_up(pull_up), .pull_down(pull_down), .ext_val(ext_val), .ext_en(ext_en),
    .pad_in(pad_in));
  // clock
  initial forever #50 ref_clk = ~ref_clk;
  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one access; the next call or rd ends it
  task automatic acc(input op_type o, input logic [2:0] f, input logic [15:0] d,
                     input logic [15:0] m, input rmw_fn_type fn);
    op = o;
    field_sel = f;
    wr_data = d;
    bit_mask = m;
    rmw_fn = fn;
    step(1);
  endtask
  task automatic rd(input logic [2:0] f, input logic [15:0] exp);
    op = op_idle;
    field_sel = f;
    step(2);
    chk(rd_data, exp);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    step(3);
    rstn = 1;
    rd(3'h1, 16'h0000);
    rd(3'h2, 16'h0000);
    chk(pad_oe_n[64 +: 16], 16'hffff);
    ext_en[64 +: 16] = 16'hffff;
    ext_val[64 +: 16] = 16'h12a5;
    acc(op_write, 3'h0, 16'hffff, 16'hffff, f_pass);
    rd(3'h0, 16'h12a5);
    chk(pad_oe_n[64 +: 16], 16'hffff);
    acc(op_rmw, 3'h0, 16'h00ff, 16'hffff, f_xor);
    ext_en = '0;
    acc(op_write, 3'h1, 16'hffff, 16'hffff, f_pass);
    rd(3'h1, 16'h3fff);
    rd(3'h0, 16'h125a);
    chk(pad_out[64 +: 16], 16'h125a);
    acc(op_rmw, 3'h0, 16'h0f0f, 16'hffff, f_and);
    acc(op_rmw, 3'h0, 16'h3000, 16'hffff, f_or);
    acc(op_rmw, 3'h0, 16'h0003, 16'h0001, f_xor);
    rd(3'h0, 16'h320b);
    acc(op_write, 3'h2, 16'h0001, 16'h0001, f_pass);
    acc(op_write, 3'h3, 16'h0001, 16'h0001, f_pass);
    acc(op_write, 3'h4, 16'h0001, 16'h0001, f_pass);
    rd(3'h2, 16'h0001);
    chk(pad_oe_n[64 +: 16], 16'hc001);
    chk(pad_out[64 +: 16], 16'h320a);
    chk(pull_up[64 +: 16], 16'h0001);
    acc(op_write, 3'h0, 16'h0000, 16'h0001, f_pass);
    acc(op_write, 3'h4, 16'h0000, 16'h0001, f_pass);
    rd(3'h0, 16'h320a);
    chk(pad_oe_n[64 +: 16], 16'hc000);
    chk(pull_down[64 +: 16], 16'h0001);
    acc(op_write, 3'h3, 16'h0000, 16'h0001, f_pass);
    rd(3'h3, 16'h0000);
    chk(pull_down[64 +: 16], 16'h0000);
    powerdown = 1;
    rd(3'h5, 16'h0000);
    chk(pad_oe_n[64 +: 16], 16'hffff);
    acc(op_write, 3'h5, 16'hffff, 16'hffff, f_pass);
    rd(3'h5, 16'h3fff);
    chk(pad_oe_n[64 +: 16], 16'hc000);
    powerdown = 0;
    rd(3'h6, 16'h0000);
    port_sel = 4'h9;
    rd(3'h0, 16'h0000);
    port_sel = 4'h4;
    acc(op_write, 3'h1, 16'h0000, 16'hffff, f_pass);
    rd(3'h1, 16'h0000);
    chk(pad_oe_n[64 +: 16], 16'hffff);
    print_verdict();
  end
endmodule
